// ### arp_pkg.sv
package arp_pkg;
  localparam logic [7:0] ADDR_TCS = 8'h0D;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0E;
  localparam logic [7:0] ADDR_CNT_LO = 8'h0F;
  localparam logic [7:0] ADDR_RLD_HI = 8'h10;
  localparam logic [7:0] ADDR_RLD_LO = 8'h11;
  localparam logic [7:0] ADDR_OUT_CTL = 8'h12;
  localparam logic [7:0] ADDR_POL_FLG = 8'h13;
  localparam logic [7:0] ADDR_DUTY_HI = 8'h17;
  localparam logic [7:0] ADDR_DUTY_LO = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
  localparam int TCS_CMP_EN = 0;
  localparam int TCS_WRAP_EN = 1;
  localparam int TCS_WRAP = 2;
  localparam int TCS_CK_LO = 3;
  localparam int POL_CMPF = 0;
  localparam int POL_OP = 1;
  localparam int OC_OE = 0;
  localparam int IRQ_CMP = 0;
  localparam int IRQ_WRAP = 1;
  localparam logic [11:0] CNT_MAX = 12'hFFF;
  localparam logic [11:0] ZERO12 = 12'h000;
  localparam logic [7:0] RESET8 = 8'h00;
  typedef enum logic [1:0] {
    CK_OFF = 2'b00,
    CK_LTIMER = 2'b01,
    CK_CPU = 2'b10,
    CK_RSVD = 2'b11
  } arp_cksel_t;
  typedef enum logic [0:0] {
    CMP_RUN = 1'b0,
    CMP_HOLD = 1'b1
  } arp_cmp_t;
endpackage

// ### arp_timer.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
module arp_timer
  import arp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic LTIMER_TICK,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic PWM_OUT,
  output logic PWM_OE,
  output logic IRQ,
  output logic WRAP_IRQ,
  output logic CMP_IRQ
);
  logic [4:0] tcs_q, tcs_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] rld_q, rld_d;
  logic oe_q, oe_d;
  logic op_q, op_d;
  logic cmpf_q, cmpf_d;
  logic [11:0] duty_q, duty_d;
  logic [11:0] shadow_q, shadow_d;
  arp_cmp_t cmp_st_q, cmp_st_d;
  logic pwm_q, pwm_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imask_q, imask_d;
  logic [7:0] rdata_d;
  logic tick;
  logic wrap_ev;
  logic cmp_ev;
  logic [11:0] cmp_val;
  arp_cksel_t cksel;

  assign cksel = arp_cksel_t'(tcs_q[TCS_CK_LO+1:TCS_CK_LO]);

  always_comb begin
    case (cksel)
      CK_OFF: tick = 1'b0;
      CK_LTIMER: tick = LTIMER_TICK;
      CK_CPU: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end

  assign wrap_ev = tick && (cnt_q == CNT_MAX);
  // The active compare value is the shadow in PWM mode, the live one else.
  assign cmp_val = oe_q ? shadow_q : duty_q;
  // A zero compare value never matches; zero is the idle reset value.
  assign cmp_ev = tick && (cmp_st_q == CMP_RUN) && (cmp_val != ZERO12) &&
                  (cnt_q == cmp_val);

  always_comb begin
    tcs_d = tcs_q;
    cnt_d = cnt_q;
    rld_d = rld_q;
    oe_d = oe_q;
    op_d = op_q;
    cmpf_d = cmpf_q;
    duty_d = duty_q;
    shadow_d = shadow_q;
    cmp_st_d = cmp_st_q;
    pwm_d = pwm_q;
    ist_d = ist_q;
    imask_d = imask_q;
    if (RD && ADDR == ADDR_TCS) tcs_d[TCS_WRAP] = 1'b0;
    if (RD && ADDR == ADDR_POL_FLG) cmpf_d = 1'b0;
    if (WR) begin
      case (ADDR)
        ADDR_TCS: begin
          tcs_d[TCS_CK_LO+1:TCS_CK_LO] = WDATA[TCS_CK_LO+1:TCS_CK_LO];
          tcs_d[TCS_WRAP_EN] = WDATA[TCS_WRAP_EN];
          tcs_d[TCS_CMP_EN] = WDATA[TCS_CMP_EN];
        end
        ADDR_RLD_HI: rld_d[11:8] = WDATA[3:0];
        ADDR_RLD_LO: rld_d[7:0] = WDATA;
        ADDR_OUT_CTL: oe_d = WDATA[OC_OE];
        ADDR_POL_FLG: op_d = WDATA[POL_OP];
        ADDR_DUTY_HI: begin
          duty_d[11:8] = WDATA[3:0];
          cmp_st_d = CMP_HOLD;
        end
        ADDR_DUTY_LO: begin
          duty_d[7:0] = WDATA;
          cmp_st_d = CMP_RUN;
        end
        ADDR_IRQ_STAT: ist_d = ist_q & ~WDATA[1:0];
        ADDR_IRQ_MASK: imask_d = WDATA[1:0];
        default: ;
      endcase
    end
    if (tick) begin
      cnt_d = wrap_ev ? rld_q : 12'(cnt_q + 12'h001);
    end
    // Events are applied after the bus clears above, so a flag that is
    // raised in the same cycle as its clearing read is kept.
    if (wrap_ev) begin
      shadow_d = duty_q;
      pwm_d = 1'b1;
      tcs_d[TCS_WRAP] = 1'b1;
      ist_d[IRQ_WRAP] = 1'b1;
    end else if (cmp_ev && oe_q) begin
      pwm_d = 1'b0;
    end
    if (cmp_ev) begin
      cmpf_d = 1'b1;
      ist_d[IRQ_CMP] = 1'b1;
    end
    if (!oe_q) pwm_d = 1'b0;
  end

  always_comb begin
    rdata_d = RESET8;
    if (RD) begin
      case (ADDR)
        ADDR_TCS: rdata_d = {3'h0, tcs_q};
        ADDR_CNT_HI: rdata_d = {4'h0, cnt_q[11:8]};
        ADDR_CNT_LO: rdata_d = cnt_q[7:0];
        ADDR_RLD_HI: rdata_d = {4'h0, rld_q[11:8]};
        ADDR_RLD_LO: rdata_d = rld_q[7:0];
        ADDR_OUT_CTL: rdata_d = {7'h00, oe_q};
        ADDR_POL_FLG: rdata_d = {6'h00, op_q, cmpf_q};
        ADDR_DUTY_HI: rdata_d = {4'h0, duty_q[11:8]};
        ADDR_DUTY_LO: rdata_d = duty_q[7:0];
        ADDR_IRQ_STAT: rdata_d = {6'h00, ist_q};
        ADDR_IRQ_MASK: rdata_d = {6'h00, imask_q};
        default: rdata_d = RESET8;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tcs_q <= 5'h00;
      cnt_q <= ZERO12;
      rld_q <= ZERO12;
      oe_q <= 1'b0;
      op_q <= 1'b0;
      cmpf_q <= 1'b0;
      duty_q <= ZERO12;
      shadow_q <= ZERO12;
      cmp_st_q <= CMP_RUN;
      pwm_q <= 1'b0;
      ist_q <= 2'h0;
      imask_q <= 2'h0;
      RDATA <= RESET8;
    end else begin
      tcs_q <= tcs_d;
      cnt_q <= cnt_d;
      rld_q <= rld_d;
      oe_q <= oe_d;
      op_q <= op_d;
      cmpf_q <= cmpf_d;
      duty_q <= duty_d;
      shadow_q <= shadow_d;
      cmp_st_q <= cmp_st_d;
      pwm_q <= pwm_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      RDATA <= rdata_d;
    end
  end

  assign PWM_OUT = oe_q & (pwm_q ^ op_q);
  assign PWM_OE = oe_q;
  assign WRAP_IRQ = tcs_q[TCS_WRAP] & tcs_q[TCS_WRAP_EN];
  assign CMP_IRQ = cmpf_q & tcs_q[TCS_CMP_EN];
  assign IRQ = |(ist_q & imask_q);

  property p_wrap_reload;
    @(posedge CLK) disable iff (!RST_B)
    wrap_ev |=> cnt_q == $past(rld_q);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload)
    else $error("Counter did not reload on overflow.");

  property p_wrap_flag;
    @(posedge CLK) disable iff (!RST_B)
    wrap_ev |=> tcs_q[TCS_WRAP] && pwm_q == $past(oe_q);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("Overflow flag or PWM high missing after overflow.");

  property p_cmp_flag;
    @(posedge CLK) disable iff (!RST_B)
    cmp_ev |=> cmpf_q;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("Compare flag not set on match.");

  property p_cmp_clear;
    @(posedge CLK) disable iff (!RST_B)
    (RD && ADDR == ADDR_POL_FLG && !cmp_ev) |=> !cmpf_q;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear)
    else $error("Compare flag not cleared by read.");

  property p_wrap_clear;
    @(posedge CLK) disable iff (!RST_B)
    (RD && ADDR == ADDR_TCS && !wrap_ev) |=> !tcs_q[TCS_WRAP];
  endproperty
  a_wrap_clear: assert property (p_wrap_clear)
    else $error("Overflow flag not cleared by read.");

  property p_hold;
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == ADDR_DUTY_HI) |=> !cmp_ev;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Compare ran after duty high write.");

  property p_pin_gate;
    @(posedge CLK) disable iff (!RST_B)
    !oe_q |-> !PWM_OUT && !PWM_OE;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("Pin driven while output disabled.");

  property p_polarity;
    @(posedge CLK) disable iff (!RST_B)
    oe_q |-> PWM_OUT == (pwm_q ^ op_q);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("Polarity not applied to PWM output.");

  property p_clk_off;
    @(posedge CLK) disable iff (!RST_B)
    (cksel == CK_OFF && !(WR && ADDR == ADDR_TCS)) |=> $stable(cnt_q);
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("Counter moved with clock off.");

  // Compare events are checked from the raw registers, not from cmp_ev, so
  // a wrong compare-value select shows up here.
  property p_pwm_match;
    @(posedge CLK) disable iff (!RST_B)
    (tick && oe_q && cmp_st_q == CMP_RUN && shadow_q != ZERO12 &&
     cnt_q == shadow_q && cnt_q != CNT_MAX) |=> !pwm_q;
  endproperty
  a_pwm_match: assert property (p_pwm_match)
    else $error("PWM output not lowered on shadow match.");

  property p_oc_match;
    @(posedge CLK) disable iff (!RST_B)
    (tick && !oe_q && cmp_st_q == CMP_RUN && duty_q != ZERO12 &&
     cnt_q == duty_q) |=> cmpf_q;
  endproperty
  a_oc_match: assert property (p_oc_match)
    else $error("Compare flag not set on duty match.");

  property p_no_set;
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == ADDR_POL_FLG && !cmpf_q && !cmp_ev) |=> !cmpf_q;
  endproperty
  a_no_set: assert property (p_no_set)
    else $error("Software write set the compare flag.");

  property p_rsvd_stop;
    @(posedge CLK) disable iff (!RST_B)
    (cksel == CK_RSVD && !(WR && ADDR == ADDR_TCS)) |=> $stable(cnt_q);
  endproperty
  a_rsvd_stop: assert property (p_rsvd_stop)
    else $error("Counter moved with reserved clock select.");

  property p_resume;
    @(posedge CLK) disable iff (!RST_B)
    (WR && ADDR == ADDR_DUTY_LO) |=> cmp_st_q == CMP_RUN;
  endproperty
  a_resume: assert property (p_resume)
    else $error("Compare not resumed after duty low write.");

  property p_cmp_irq_gate;
    @(posedge CLK) disable iff (!RST_B)
    !tcs_q[TCS_CMP_EN] |-> !CMP_IRQ;
  endproperty
  a_cmp_irq_gate: assert property (p_cmp_irq_gate)
    else $error("Compare interrupt raised while disabled.");

  property p_wrap_irq_gate;
    @(posedge CLK) disable iff (!RST_B)
    (wrap_ev && tcs_q[TCS_WRAP_EN] && !(WR && ADDR == ADDR_TCS)) |=>
    WRAP_IRQ;
  endproperty
  a_wrap_irq_gate: assert property (p_wrap_irq_gate)
    else $error("Overflow interrupt missing while enabled.");

  c_wrap: cover property (@(posedge CLK) disable iff (!RST_B) wrap_ev);
  c_cmp_pwm: cover property (@(posedge CLK) disable iff (!RST_B)
    cmp_ev && oe_q);
  c_cmp_oc: cover property (@(posedge CLK) disable iff (!RST_B)
    cmp_ev && !oe_q);
  c_irq: cover property (@(posedge CLK) disable iff (!RST_B) IRQ);
  c_hold: cover property (@(posedge CLK) disable iff (!RST_B)
    tick && cmp_st_q == CMP_HOLD);
endmodule

// ### arp_timer_test.sv
`timescale 1ns/1ps
module arp_timer_test;
  import arp_pkg::*;
  logic clk, rst_b, tick, wr_s, rd_s;
  logic [7:0] addr, wdata, rdata, v;
  logic pwm_out, pwm_oe, irq, wrap_irq, cmp_irq;
  int err_count = 0;
  int num_checks = 0;
  int i, n, expc;
  logic [7:0] regs [12] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h17, 8'h18, 8'h20, 8'h21, 8'h14};
  logic [1:0] sel [3] = '{2'b00, 2'b01, 2'b11};

  arp_timer DUT (.CLK(clk), .RST_B(rst_b), .LTIMER_TICK(tick), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .PWM_OUT(pwm_out),
    .PWM_OE(pwm_oe), .IRQ(irq), .WRAP_IRQ(wrap_irq), .CMP_IRQ(cmp_irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // The strobe drops one edge before the next call may raise it again.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    chk(q, exp, "read data");
  endtask

  // Sixteen cycles cover exactly one reload period from FF0 to FFF.
  task automatic high_count(input int exp);
    n = 0;
    repeat (16) begin
      @(posedge clk);
      #1 n += (pwm_out === 1'b1) ? 1 : 0;
    end
    chk(8'(n), 8'(exp), "pwm high cycles");
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end

  initial begin
    rst_b = 1'b0;
    tick = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({6'h00, pwm_oe, pwm_out}, 8'h00, "pins after reset");
    foreach (regs[k]) rdc(regs[k], 8'h00);
    wr(ADDR_RLD_HI, 8'h0F);
    rdc(ADDR_RLD_HI, 8'h0F);
    wr(ADDR_RLD_LO, 8'hF0);
    rdc(ADDR_RLD_LO, 8'hF0);
    wr(ADDR_CNT_LO, 8'h55);
    rdc(ADDR_CNT_LO, 8'h00);
    wr(ADDR_POL_FLG, 8'h01);
    rdc(ADDR_POL_FLG, 8'h00);
    expc = 0;
    foreach (sel[k]) begin
      wr(ADDR_TCS, {3'b000, sel[k], 3'b000});
      repeat (3) begin
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
      end
      expc += (sel[k] == 2'b01) ? 3 : 0;
      rdc(ADDR_CNT_LO, 8'(expc));
    end
    wr(ADDR_DUTY_HI, 8'h00);
    wr(ADDR_DUTY_LO, 8'h05);
    wr(ADDR_TCS, 8'h11);
    for (i = 0; i < 100 && cmp_irq !== 1'b1; i++) @(posedge clk);
    chk({7'h00, cmp_irq}, 8'h01, "compare irq");
    chk({7'h00, irq}, 8'h00, "masked irq");
    wr(ADDR_IRQ_MASK, 8'h03);
    chk({7'h00, irq}, 8'h01, "unmasked irq");
    rdc(ADDR_POL_FLG, 8'h01);
    rdc(ADDR_POL_FLG, 8'h00);
    chk({7'h00, cmp_irq}, 8'h00, "compare irq cleared");
    wr(ADDR_IRQ_STAT, 8'h01);
    chk({7'h00, irq}, 8'h00, "irq after clear");
    wr(ADDR_TCS, 8'h12);
    for (i = 0; i < 5000 && wrap_irq !== 1'b1; i++) @(posedge clk);
    chk({7'h00, wrap_irq}, 8'h01, "overflow irq");
    rdc(ADDR_IRQ_STAT, 8'h02);
    rdc(ADDR_TCS, 8'h16);
    rdc(ADDR_TCS, 8'h12);
    rd(ADDR_CNT_HI, v);
    chk(v, 8'h0F, "counter after reload");
    wr(ADDR_TCS, 8'h10);
    wr(ADDR_DUTY_HI, 8'h0F);
    wr(ADDR_DUTY_LO, 8'hF8);
    // A match at FF8 comes every period, so only the hold can hide it.
    wr(ADDR_DUTY_HI, 8'h0F);
    rd(ADDR_POL_FLG, v);
    repeat (40) @(posedge clk);
    rdc(ADDR_POL_FLG, 8'h00);
    wr(ADDR_DUTY_LO, 8'hF8);
    repeat (20) @(posedge clk);
    rdc(ADDR_POL_FLG, 8'h01);
    wr(ADDR_OUT_CTL, 8'h01);
    chk({7'h00, pwm_oe}, 8'h01, "pin driven");
    repeat (40) @(posedge clk);
    high_count(9);
    wr(ADDR_POL_FLG, 8'h02);
    high_count(7);
    wr(ADDR_OUT_CTL, 8'h00);
    #1 chk({6'h00, pwm_oe, pwm_out}, 8'h00, "pin released");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({5'h00, irq, wrap_irq, pwm_oe}, 8'h00, "pins after reset");
    foreach (regs[k]) rdc(regs[k], 8'h00);
    report_and_stop;
  end
endmodule
